// >>> logic/bst_tap.v
// boundary scan test access port top
`timescale 1ns/1ps
`include "bst_tap_map.vh"
module bst_tap #(
    parameter       NUM_IN     = 4,
    parameter       NUM_OUT    = 4,
    parameter       IS_XCVR    = 1
) (
    input  wire               clk_sys,
    input  wire               arst_n,
    input  wire               tck,
    input  wire               tms,
    input  wire               tdi,
    input  wire               trst_n,
    output reg                tdo,
    output reg                tdo_oe,
    input  wire [NUM_IN-1:0]  core_in_pin,
    input  wire [NUM_OUT-1:0] core_out,
    input  wire [NUM_OUT-1:0] core_out_oe,
    output reg  [NUM_OUT-1:0] pin_out,
    output reg  [NUM_OUT-1:0] pin_out_oe
);
    localparam BSR_W = NUM_IN + 2 * NUM_OUT;

    // pull-ups act before sampling: a floating pin appears as x in the bench,
    // so x/z on the raw pins is resolved high here
    wire tck_pu  = (tck === 1'b0) ? 1'b0 : 1'b1;
    wire tms_pu  = (tms === 1'b0) ? 1'b0 : 1'b1;
    wire tdi_pu  = (tdi === 1'b0) ? 1'b0 : 1'b1;
    wire trst_pu = (trst_n === 1'b0) ? 1'b0 : 1'b1;

    reg [1:0] tck_sy;
    reg [1:0] tms_sy;
    reg [1:0] tdi_sy;
    reg [1:0] trst_sy;
    reg       tck_d;
    reg [NUM_IN-1:0] in_sy1;
    reg [NUM_IN-1:0] in_sy2;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tck_sy  <= 2'h0;
            tms_sy  <= 2'h3;
            tdi_sy  <= 2'h3;
            trst_sy <= 2'h0;
            tck_d   <= 1'b0;
            in_sy1  <= {NUM_IN{1'b0}};
            in_sy2  <= {NUM_IN{1'b0}};
        end else begin
            tck_sy  <= {tck_sy[0], tck_pu};
            tms_sy  <= {tms_sy[0], tms_pu};
            tdi_sy  <= {tdi_sy[0], tdi_pu};
            trst_sy <= {trst_sy[0], trst_pu};
            tck_d   <= tck_sy[1];
            in_sy1  <= core_in_pin;
            in_sy2  <= in_sy1;
        end
    end

    // edges found by sampling; a halted clock simply yields no edges
    wire rise = tck_sy[1] & ~tck_d;
    wire fall = ~tck_sy[1] & tck_d;
    wire trst_act = ~trst_sy[1];

    wire [3:0] state;

    bst_tap_fsm u_fsm (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .test_rst (trst_act),
        .step     (fall),
        .tms      (tms_sy[1]),
        .state    (state)
    );

    reg [`BST_IR_W-1:0]  ir_sh;
    reg [`BST_IR_W-1:0]  ir;
    reg                  byp;
    reg [`BST_ID_W-1:0]  id_sh;
    reg [BSR_W-1:0]      bsr_sh;
    reg [BSR_W-1:0]      bsr_upd;

    // identification code; values arbitrary
    wire [`BST_ID_W-1:0] id_val = IS_XCVR ? `BST_ID_XCVR : `BST_ID_PROC;

    function is_known;
        input [`BST_IR_W-1:0] op;
        begin
            is_known = (op == `BST_OP_EXTEST) || (op == `BST_OP_SAMPLE) ||
                       (op == `BST_OP_IDCODE) || (op == `BST_OP_HIGHZ);
        end
    endfunction

    wire sel_id  = (ir == `BST_OP_IDCODE);
    wire sel_bsr = (ir == `BST_OP_SAMPLE) || (ir == `BST_OP_EXTEST);
    wire sel_byp = !is_known(ir);

    // cell layout: [inputs][output data][output enables]
    wire [BSR_W-1:0] bsr_cap = {in_sy2, core_out, core_out_oe};

    // shifting happens on the rising test clock edge, per the standard
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ir_sh   <= `BST_IR_CAPTURE;
            ir      <= `BST_OP_IDCODE;
            byp     <= 1'b0;
            id_sh   <= {`BST_ID_W{1'b0}};
            bsr_sh  <= {BSR_W{1'b0}};
            bsr_upd <= {BSR_W{1'b0}};
        end else if (trst_act || (state == `BST_ST_RESET)) begin
            ir <= `BST_OP_IDCODE;
        end else if (rise) begin
            case (state)
                `BST_ST_CAP_IR: begin
                    ir_sh <= `BST_IR_CAPTURE;
                end
                `BST_ST_SHIFT_IR: begin
                    ir_sh <= {tdi_sy[1], ir_sh[`BST_IR_W-1:1]};
                end
                `BST_ST_CAP_DR: begin
                    byp <= 1'b0;
                    if (sel_id) begin
                        id_sh <= id_val;
                    end
                    if (sel_bsr) begin
                        bsr_sh <= bsr_cap;
                    end
                end
                `BST_ST_SHIFT_DR: begin
                    byp <= tdi_sy[1];
                    if (sel_id) begin
                        id_sh <= {tdi_sy[1], id_sh[`BST_ID_W-1:1]};
                    end
                    if (sel_bsr) begin
                        bsr_sh <= {tdi_sy[1], bsr_sh[BSR_W-1:1]};
                    end
                end
                default: begin
                    ir_sh <= ir_sh;
                end
            endcase
        end else if (fall) begin
            // updates on the falling edge so parallel outputs change cleanly
            if (state == `BST_ST_UPD_IR) begin
                ir <= ir_sh;
            end
            if ((state == `BST_ST_UPD_DR) && sel_bsr) begin
                bsr_upd <= bsr_sh;
            end
        end
    end

    reg next_tdo;
    reg next_tdo_oe;
    // one cycle late so the state already shows where the fall led
    reg fall_d;

    always @* begin
        next_tdo    = tdo;
        next_tdo_oe = 1'b0;
        if (state == `BST_ST_SHIFT_IR) begin
            next_tdo    = ir_sh[0];
            next_tdo_oe = 1'b1;
        end else if (state == `BST_ST_SHIFT_DR) begin
            next_tdo_oe = 1'b1;
            if (sel_id) begin
                next_tdo = id_sh[0];
            end else if (sel_bsr) begin
                next_tdo = bsr_sh[0];
            end else begin
                next_tdo = byp;
            end
        end
    end

    // tdo changes on falling edge only; enable follows shift states
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tdo        <= 1'b0;
            tdo_oe     <= 1'b0;
            fall_d     <= 1'b0;
            pin_out    <= {NUM_OUT{1'b0}};
            pin_out_oe <= {NUM_OUT{1'b0}};
        end else begin
            fall_d <= fall;
            if (trst_act) begin
                tdo_oe <= 1'b0;
            end else if (fall_d) begin
                tdo    <= next_tdo;
                tdo_oe <= next_tdo_oe;
            end
            if (ir == `BST_OP_HIGHZ) begin
                pin_out    <= core_out;
                pin_out_oe <= {NUM_OUT{1'b0}};
            end else if (ir == `BST_OP_EXTEST) begin
                pin_out    <= bsr_upd[2*NUM_OUT-1:NUM_OUT];
                pin_out_oe <= bsr_upd[NUM_OUT-1:0];
            end else begin
                pin_out    <= core_out;
                pin_out_oe <= core_out_oe;
            end
        end
    end

endmodule // bst_tap

// >>> logic/bst_tap_map.vh
// constants for the boundary scan test access port
`ifndef BST_TAP_MAP_VH
`define BST_TAP_MAP_VH
`define BST_ST_RESET      4'h0
`define BST_ST_IDLE       4'h1
`define BST_ST_SEL_DR     4'h2
`define BST_ST_CAP_DR     4'h3
`define BST_ST_SHIFT_DR   4'h4
`define BST_ST_EXIT1_DR   4'h5
`define BST_ST_PAUSE_DR   4'h6
`define BST_ST_EXIT2_DR   4'h7
`define BST_ST_UPD_DR     4'h8
`define BST_ST_SEL_IR     4'h9
`define BST_ST_CAP_IR     4'hA
`define BST_ST_SHIFT_IR   4'hB
`define BST_ST_EXIT1_IR   4'hC
`define BST_ST_PAUSE_IR   4'hD
`define BST_ST_EXIT2_IR   4'hE
`define BST_ST_UPD_IR     4'hF
`define BST_IR_W          4
`define BST_OP_EXTEST     4'h0
`define BST_OP_SAMPLE     4'h1
`define BST_OP_IDCODE     4'h2
`define BST_OP_HIGHZ      4'h3
`define BST_OP_BYPASS     4'hF
`define BST_IR_CAPTURE    4'h1
`define BST_TCK_MAX_MHZ   5
`define BST_SYS_MHZ       100
`define BST_ID_W          32
`define BST_ID_XCVR       32'h0000_0A01
`define BST_ID_PROC       32'h0000_0A03
`endif

// >>> logic/bst_tap_fsm.v
// tap controller state machine, stepped by a falling edge strobe
`timescale 1ns/1ps
`include "bst_tap_map.vh"
module bst_tap_fsm (
    input  wire       clk_sys,
    input  wire       arst_n,
    input  wire       test_rst,
    input  wire       step,
    input  wire       tms,
    output reg  [3:0] state
);
    reg [3:0] next_state;

    always @* begin
        next_state = state;
        case (state)
            `BST_ST_RESET:    next_state = tms ? `BST_ST_RESET : `BST_ST_IDLE;
            `BST_ST_IDLE:     next_state = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
            `BST_ST_SEL_DR:   next_state = tms ? `BST_ST_SEL_IR : `BST_ST_CAP_DR;
            `BST_ST_CAP_DR:   next_state = tms ? `BST_ST_EXIT1_DR : `BST_ST_SHIFT_DR;
            `BST_ST_SHIFT_DR: next_state = tms ? `BST_ST_EXIT1_DR : `BST_ST_SHIFT_DR;
            `BST_ST_EXIT1_DR: next_state = tms ? `BST_ST_UPD_DR : `BST_ST_PAUSE_DR;
            `BST_ST_PAUSE_DR: next_state = tms ? `BST_ST_EXIT2_DR : `BST_ST_PAUSE_DR;
            `BST_ST_EXIT2_DR: next_state = tms ? `BST_ST_UPD_DR : `BST_ST_SHIFT_DR;
            `BST_ST_UPD_DR:   next_state = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
            `BST_ST_SEL_IR:   next_state = tms ? `BST_ST_RESET : `BST_ST_CAP_IR;
            `BST_ST_CAP_IR:   next_state = tms ? `BST_ST_EXIT1_IR : `BST_ST_SHIFT_IR;
            `BST_ST_SHIFT_IR: next_state = tms ? `BST_ST_EXIT1_IR : `BST_ST_SHIFT_IR;
            `BST_ST_EXIT1_IR: next_state = tms ? `BST_ST_UPD_IR : `BST_ST_PAUSE_IR;
            `BST_ST_PAUSE_IR: next_state = tms ? `BST_ST_EXIT2_IR : `BST_ST_PAUSE_IR;
            `BST_ST_EXIT2_IR: next_state = tms ? `BST_ST_UPD_IR : `BST_ST_SHIFT_IR;
            `BST_ST_UPD_IR:   next_state = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
            default:          next_state = `BST_ST_RESET;
        endcase
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= `BST_ST_RESET;
        end else if (test_rst) begin
            state <= `BST_ST_RESET;
        end else if (step) begin
            state <= next_state;
        end
    end
endmodule // bst_tap_fsm

// >>> sim/bst_tap_sva.sv
// port checker for the boundary scan port
`timescale 1ns/1ps
module bst_tap_sva #(
    parameter NUM_OUT = 4
) (
    input wire               clk_sys,
    input wire               arst_n,
    input wire               tck,
    input wire               trst_n,
    input wire               tdo,
    input wire               tdo_oe,
    input wire [NUM_OUT-1:0] core_out,
    input wire [NUM_OUT-1:0] core_out_oe,
    input wire [NUM_OUT-1:0] pin_out,
    input wire [NUM_OUT-1:0] pin_out_oe
);
    reg [3:0] since_fall;
    // saturates so a stopped test clock never wraps back into the window
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            since_fall <= 4'hF;
        else if ($fell(tck))
            since_fall <= 4'h0;
        else if (since_fall != 4'hF)
            since_fall <= since_fall + 4'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    tdo_edge_a: assert property (($changed(tdo) || $changed(tdo_oe)) && trst_n
        && $past(trst_n, 4) |-> since_fall < 4'h8) else $error("tdo moved off a clock fall");
    tdo_stall_a: assert property ((trst_n && $stable(tck)) [*7]
        |-> $stable(tdo) && $stable(tdo_oe)) else $error("tdo moved with clock stopped");
    rise_quiet_a: assert property ($rose(tck) && trst_n |=> $stable(tdo) [*5])
        else $error("tdo moved after a clock rise");
    trst_hold_a: assert property (!trst_n [*4] |-> !tdo_oe)
        else $error("tdo driven in test reset");
    trst_fast_a: assert property ($fell(trst_n) |-> ##[1:4] !tdo_oe)
        else $error("test reset too slow");
    arst_idle_a: assert property ($rose(arst_n) |-> !tdo_oe [*2])
        else $error("tdo driven after reset");
    pin_oe_a: assert property ($changed(pin_out_oe) && trst_n
        && pin_out_oe != $past(core_out_oe) && pin_out_oe != $past(core_out_oe, 2)
        |-> since_fall < 4'h8) else $error("pad enable moved off a clock fall");
    pin_data_a: assert property ($changed(pin_out) && trst_n
        && pin_out != $past(core_out) && pin_out != $past(core_out, 2)
        |-> since_fall < 4'h8) else $error("pad data moved off a clock fall");
    cover property ($rose(tdo_oe));
    cover property (pin_out_oe == 0 && core_out_oe != 0);
    cover property (!trst_n);
endmodule // bst_tap_sva
bind bst_tap bst_tap_sva #(.NUM_OUT(NUM_OUT)) u_sva (
    .clk_sys(clk_sys), .arst_n(arst_n), .tck(tck), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe), .core_out(core_out), .core_out_oe(core_out_oe), .pin_out(pin_out),
    .pin_out_oe(pin_out_oe));

// >>> sim/bst_tap_tester.sv
// test port master model driving the scan pins
`timescale 1ns/1ps
module bst_tap_tester (
    input  wire clk_sys,
    input  wire tdo,
    input  wire tdo_oe,
    output reg  tck,
    output reg  tms,
    output reg  tdi
);
    wire line = tdo_oe ? tdo : 1'b1; // released line floats to the pull-up
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // 160 ns period; mode and data move mid low phase, clock idles low
    task step(input m, input d, output q, output e);
        begin
            @(posedge clk_sys);
            tms <= m;
            tdi <= d;
            repeat (4) @(posedge clk_sys);
            q = line;
            e = tdo_oe;
            tck <= 1'b1;
            repeat (8) @(posedge clk_sys);
            tck <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
    endtask
endmodule // bst_tap_tester

// >>> sim/tb.sv
// self-checking bench for the boundary scan port
`timescale 1ns/1ps
`include "bst_tap_map.vh"
module tb;
    reg         clk_sys, arst_n, trst_n, q, e;
    reg  [3:0]  core_in_pin, core_out, core_out_oe;
    wire        tck, tms, tdi, tdo, tdo_oe;
    wire [3:0]  pin_out, pin_out_oe;
    reg  [31:0] got;
    integer     n_mismatch, samples_checked, i;
    bst_tap dut (.clk_sys(clk_sys), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .core_in_pin(core_in_pin),
        .core_out(core_out), .core_out_oe(core_out_oe), .pin_out(pin_out),
        .pin_out_oe(pin_out_oe));
    bst_tap_tester tester (.clk_sys(clk_sys), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck),
        .tms(tms), .tdi(tdi));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task check(input [31:0] exp, input [31:0] act);
        begin
            samples_checked = samples_checked + 1;
            if (act !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value at %0t: expected %h, got %h", $time, exp, act);
            end
        end
    endtask
    // one scan from idle back to idle, lsb first
    task scan(input ir, input [31:0] din, input integer n, output [31:0] dout);
        begin
            dout = 32'h0;
            tester.step(1'b1, 1'b1, q, e);
            if (ir) tester.step(1'b1, 1'b1, q, e);
            tester.step(1'b0, 1'b1, q, e);
            tester.step(1'b0, 1'b1, q, e);
            for (i = 0; i < n; i = i + 1) begin
                tester.step(i == n - 1, din[i], q, e);
                dout[i] = q;
                check(32'h1, {31'h0, e});
            end
            tester.step(1'b1, 1'b1, q, e);
            tester.step(1'b0, 1'b1, q, e);
            check(32'h0, {31'h0, e});
        end
    endtask
    task read_id;
        begin
            tester.step(1'b0, 1'b1, q, e);
            scan(1'b0, 32'h0, 32, got);
            check(`BST_ID_XCVR, got);
        end
    endtask
    task ir_bypass;
        begin
            scan(1'b1, `BST_OP_BYPASS, 4, got);
            check({28'h0, `BST_IR_CAPTURE}, got);
            scan(1'b0, 32'h0000_00B6, 8, got);
            check(32'h0000_006C, got);
        end
    endtask
    // preload under sample must leave the pads on core data
    task sample_extest;
        begin
            scan(1'b1, `BST_OP_SAMPLE, 4, got);
            scan(1'b0, 32'h0000_0963, 12, got);
            check(32'h0000_0A5C, got);
            check({28'h0, core_out}, {28'h0, pin_out});
            scan(1'b1, `BST_OP_EXTEST, 4, got);
            repeat (4) @(posedge clk_sys);
            check(32'h0000_0063, {24'h0, pin_out, pin_out_oe});
            scan(1'b0, 32'h0, 12, got);
            check(32'h0000_000A, {28'h0, got[11:8]});
        end
    endtask
    task highz;
        begin
            scan(1'b1, `BST_OP_HIGHZ, 4, got);
            repeat (4) @(posedge clk_sys);
            check(32'h0, {28'h0, pin_out_oe});
        end
    endtask
    // test clock held still through the whole reset
    task test_reset;
        begin
            @(posedge clk_sys);
            trst_n <= 1'b0;
            repeat (10) @(posedge clk_sys);
            trst_n <= 1'b1;
            repeat (200) @(posedge clk_sys);
            check(32'h0000_000C, {28'h0, pin_out_oe});
            read_id;
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch = n_mismatch + 1;
        give_verdict;
    end
    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        arst_n = 1'b0;
        trst_n = 1'b1;
        core_in_pin = 4'hA;
        core_out = 4'h5;
        core_out_oe = 4'hC;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        read_id;
        ir_bypass;
        sample_extest;
        highz;
        test_reset;
        give_verdict;
    end
endmodule // tb
